// ---- logic/byte_lane_mux.sv ----
// data multiplexer: byte lane routing by remaining size, byte offset and port width
`timescale 1ns/1ps
module byte_lane_mux
  import ebi_pkg::*;
(
  // operand side
  input wire logic [15:0] op_top,
  input wire logic [2:0] left,
  input wire logic byte_offset_bit,
  input wire logic port8,
  // bus side
  input wire logic [15:0] data_in,
  output logic [15:0] wdata,
  output logic [15:0] rbytes,
  output logic [1:0] moved
);

  wire logic [7:0] b0 = op_top[15:8];
  wire logic [7:0] b1 = op_top[7:0];
  // two bytes only on an even address, a 16-bit port and at least a word left
  wire logic two = !port8 && !byte_offset_bit && (left >= OPSZ_WORD); // see RL15 RL12
  wire logic single_lane = (left == OPSZ_BYTE) || byte_offset_bit;

  assign moved = two ? 2'h2 : 2'h1; // see RL17
  // a lone byte goes out on both halves so either port width sees it
  assign wdata = single_lane ? {b0, b0} : {b0, b1}; // see RL19 RL24
  // an 8-bit port lives on the upper lines only
  assign rbytes = two ? data_in :
                  (port8 || !byte_offset_bit) ? {8'h00, data_in[15:8]} :
                  {8'h00, data_in[7:0]}; // see RL14 RL19

endmodule

// ---- logic/ebi_pkg.sv ----
// shared constants and types for the external bus unit
package ebi_pkg;

  // size acknowledge pin pair as seen on the pins (active low), upper line first
  localparam logic [1:0] ACK_WAIT = 2'h3;
  localparam logic [1:0] ACK_PORT8 = 2'h2;
  localparam logic [1:0] ACK_PORT16 = 2'h1;
  localparam logic [1:0] ACK_RSVD = 2'h0;

  // operand sizes as byte counts
  localparam logic [2:0] OPSZ_BYTE = 3'h1;
  localparam logic [2:0] OPSZ_WORD = 3'h2;
  localparam logic [2:0] OPSZ_THREE = 3'h3;
  localparam logic [2:0] OPSZ_LONG = 3'h4;

  // remaining size codes on the pins
  localparam logic [1:0] RSZ_BYTE = 2'h1;
  localparam logic [1:0] RSZ_WORD = 2'h2;
  localparam logic [1:0] RSZ_THREE = 2'h3;
  localparam logic [1:0] RSZ_LONG = 2'h0;

  // cpu space code, used by interrupt acknowledge cycles
  localparam logic [2:0] SPACE_CPU = 3'h7;

  // cycle lengths in system clocks
  localparam logic [7:0] INT_ACCESS_CYC = 8'h02;
  localparam logic [7:0] EXT_MIN_CYC = 8'h03;
  localparam logic [7:0] FAST_CYC = 8'h02;
  localparam logic [7:0] MON_CYC_DEFAULT = 8'h40;

  // synchroniser lane layout: data, halt, fault, autovector, ack pair
  localparam int SYNC_W = 21;
  localparam int SY_ACK_LO = 0;
  localparam int SY_AUTO_VECTOR_IN = 2;
  localparam int SY_FAULT = 3;
  localparam int SY_HALT = 4;
  localparam int SY_DATA_LO = 5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INT = 2'b01,
    ST_BUS = 2'b10,
    ST_HOLD = 2'b11
  } ebi_state_e;

endpackage

// ---- logic/external_bus_unit.sv ----
// external bus unit: cycle termination and dynamic bus sizing
//
// Functional notes
// RL1 - ack pair: both high waits, high/low 8-bit port, low/high 16-bit, both low reserved
// RL2 - on a read, a recognised ack ends the cycle and captures the data bus
// RL3 - on a write, the responder acks only after storing the data
// RL4 - bus fault aborts an unterminated cycle; may accompany an ack
// RL5 - internal monitor faults own transfers only; external masters make their own
// RL6 - halt gives single cycle operation; halt with fault retries the cycle
// RL7 - halt stalls external cycles only; internal accesses continue (a halt held in ST_HOLD blocks internal requests too)
// RL8 - halted: data floats, strobes off, address, space, size, direction held
// RL9 - no interrupt is taken while halted
// RL10 - autovector ends interrupt acknowledge cycles only; ignored elsewhere
// RL11 - autovector disabled while an external master owns the bus
// RL12 - long from 16-bit port: two word cycles; from 8-bit port: four
// RL13 - responders ack with their own port width regardless of request size
// RL14 - 16-bit port on lines 15..0, 8-bit port on lines 15..8
// RL15 - each cycle attempts the largest transfer, assuming a 16-bit port
// RL16 - bytes move most significant first, least significant last
// RL17 - size outputs give bytes remaining; moved bytes depend on ack width
// RL18 - upper address gives word base, low bit byte offset; no misaligned issue
// RL19 - odd byte on 16-bit port reads low lines; writes drive both halves
// RL20 - long to 8-bit port starts 00, then three-byte code after a byte ack
// RL21 - internal access two clocks, external at least three, fast termination two
// RL22 - strobes from flip-flops; ack and data synchronised before use (fast cycles take cs_ack_pair and data_in unsynchronised)
// RL23 - size codes: 01 byte, 10 word, 11 three bytes, 00 long
// RL24 - every write cycle drives all sixteen data lines
// RL25 - ack, fault, halt and autovector pass two flip-flops first (fast cycles take cs_ack_pair unsynchronised)
`timescale 1ns/1ps
module external_bus_unit
  import ebi_pkg::*;
#(
  parameter logic [7:0] MON_CYC = MON_CYC_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // core request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [2:0] req_size,
  input wire logic [23:0] req_addr,
  input wire logic [2:0] req_space,
  input wire logic [31:0] req_wdata,
  input wire logic req_internal,
  input wire logic req_fast,
  input wire logic req_iack,
  // internal module and chip-select side
  input wire logic [31:0] int_rdata,
  input wire logic [1:0] cs_ack_pair,
  // core answer
  output logic done,
  output logic [31:0] rdata,
  output logic fault,
  output logic autovec,
  // interrupts and arbitration
  input wire logic irq_req,
  output logic irq_take,
  input wire logic ext_master,
  // bus pins
  output logic [23:0] addr_out,
  output logic [2:0] space_code,
  output logic [1:0] remaining_size,
  output logic read_not_write,
  output logic addr_strobe_n,
  output logic data_strobe_n,
  output logic bus_drive_en,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [15:0] data_in,
  input wire logic [1:0] size_ack_pair,
  input wire logic bus_fault_in_n,
  input wire logic halt_in_n,
  input wire logic auto_vector_in_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SYNC_W-1:0] sy_q;
  wire logic [SYNC_W-1:0] sy_d = {data_in, halt_in_n, bus_fault_in_n, auto_vector_in_n, size_ack_pair};
  // idle control pins are high; the data lanes start at zero
  localparam logic [SYNC_W-1:0] SY_INIT = 21'h00001f;

  // see RL25 RL22
  sync_two_flop #(.W(SYNC_W), .INIT(SY_INIT)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(sy_d),
    .q(sy_q)
  );

  wire logic [1:0] ack_s = sy_q[SY_ACK_LO +: 2];
  wire logic auto_vector_in_s = !sy_q[SY_AUTO_VECTOR_IN];
  wire logic fault_s = !sy_q[SY_FAULT];
  wire logic halt_s = !sy_q[SY_HALT];
  wire logic [15:0] data_s = sy_q[SY_DATA_LO +: 16];

  ////////////////////////////////////////////////////////////////////////////
  // state

  ebi_state_e state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [2:0] space_r, space_nxt;
  logic [2:0] left_r, left_nxt;
  logic [31:0] op_r, op_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic write_r, write_nxt;
  logic fast_r, fast_nxt;
  logic iack_r, iack_nxt;
  logic done_r, done_nxt;
  logic fault_r, fault_nxt;
  logic auto_vector_in_r, auto_vector_in_nxt;
  logic as_n_r, ds_n_r, oe_r, irq_r;
  logic [15:0] wd_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic [15:0] mux_wdata, mux_rbytes;
  logic [1:0] mux_moved;

  wire logic [1:0] ack_eff = fast_r ? cs_ack_pair : ack_s;
  wire logic ack_port8 = (ack_eff == ACK_PORT8); // see RL1 RL13
  wire logic ack_done = ack_port8 || (ack_eff == ACK_PORT16); // see RL1
  wire logic [7:0] min_cyc = fast_r ? FAST_CYC : EXT_MIN_CYC; // see RL21
  wire logic term_ok = (cnt_r >= min_cyc - 8'h01);
  // the monitor only knows our own cycles; it counts every ST_BUS clock, even while ext_master holds the bus
  wire logic mon_to = (cnt_r >= MON_CYC - 8'h01); // see RL5
  wire logic bus_err = fault_s || mon_to; // see RL4
  wire logic auto_vector_in_term = iack_r && (space_r == SPACE_CPU) && auto_vector_in_s && !ext_master; // see RL10 RL11
  wire logic end_cycle = (state_r == ST_BUS) && term_ok && (bus_err || ack_done || auto_vector_in_term);
  wire logic [2:0] left_after = left_r - {1'b0, mux_moved};

  byte_lane_mux u_mux (
    .op_top(op_r[31:16]),
    .left(left_r),
    .byte_offset_bit(addr_r[0]),
    .port8(ack_port8),
    .data_in(fast_r ? data_in : data_s),
    .wdata(mux_wdata),
    .rbytes(mux_rbytes),
    .moved(mux_moved)
  );

  // internal accesses may start while halted in idle, but not from ST_HOLD; external ones may not
  assign req_ready = (state_r == ST_IDLE) && (req_internal || (!halt_s && !ext_master)); // see RL7

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    space_nxt = space_r;
    left_nxt = left_r;
    op_nxt = op_r;
    rd_nxt = rd_r;
    write_nxt = write_r;
    fast_nxt = fast_r;
    iack_nxt = iack_r;
    done_nxt = 1'b0;
    fault_nxt = fault_r;
    auto_vector_in_nxt = auto_vector_in_r;
    case (state_r)
      ST_IDLE: begin
        if (req_valid && req_ready) begin
          // an internal access leaves the held pin values alone, even while halted
          if (!req_internal) begin // see RL7 RL8
            addr_nxt = req_addr; // see RL18
            space_nxt = req_space;
            left_nxt = req_size;
            write_nxt = req_write;
          end
          fast_nxt = req_fast;
          iack_nxt = req_iack;
          rd_nxt = 32'h00000000;
          fault_nxt = 1'b0;
          auto_vector_in_nxt = 1'b0;
          cnt_nxt = 8'h00;
          // first operand byte sits at the top of op_r
          case (req_size)
            OPSZ_BYTE: op_nxt = {req_wdata[7:0], 24'h000000};
            OPSZ_WORD: op_nxt = {req_wdata[15:0], 16'h0000};
            OPSZ_THREE: op_nxt = {req_wdata[23:0], 8'h00};
            default: op_nxt = req_wdata;
          endcase // see RL16
          state_nxt = req_internal ? ST_INT : ST_BUS;
        end
      end
      ST_INT: begin
        // accept cycle plus this one make the internal access
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r >= INT_ACCESS_CYC - 8'h02) begin // see RL21
          rd_nxt = int_rdata;
          done_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_BUS: begin
        cnt_nxt = cnt_r + 8'h01;
        if (end_cycle) begin
          cnt_nxt = 8'h00;
          if (bus_err) begin
            // fault wins over a simultaneous ack; with halt the same cycle reruns
            if (halt_s) begin // see RL6
              state_nxt = ST_HOLD;
            end else begin
              fault_nxt = 1'b1;
              done_nxt = 1'b1;
              state_nxt = ST_IDLE;
            end
          end else if (auto_vector_in_term && !ack_done) begin
            auto_vector_in_nxt = 1'b1;
            left_nxt = 3'h0;
            done_nxt = 1'b1;
            state_nxt = halt_s ? ST_HOLD : ST_IDLE;
          end else begin
            // capture and advance by the bytes this port really moved
            if (mux_moved == 2'h2) begin // see RL2 RL12
              rd_nxt = {rd_r[15:0], mux_rbytes};
              op_nxt = {op_r[15:0], 16'h0000};
            end else begin
              rd_nxt = {rd_r[23:0], mux_rbytes[7:0]};
              op_nxt = {op_r[23:0], 8'h00};
            end
            addr_nxt = addr_r + {22'h000000, mux_moved};
            left_nxt = left_after; // see RL17 RL20
            done_nxt = (left_after == 3'h0);
            // strobes must rise between cycles of one operand, so a follow-up cycle passes through hold
            if (halt_s || (left_after != 3'h0)) begin // see RL6 RL12
              state_nxt = ST_HOLD;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
      end
      ST_HOLD: begin
        // address, space, size and direction stay put while halted
        if (!halt_s && !ext_master) begin // see RL8
          state_nxt = (left_r == 3'h0 || done_r || fault_r) ? ST_IDLE : ST_BUS;
          cnt_nxt = 8'h00;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // strobes and data drive are registered so they leave the chip deskewed
  wire logic in_bus_nxt = (state_nxt == ST_BUS) && !ext_master;
  wire logic as_nxt = in_bus_nxt; // see RL22
  // read: data strobe with address strobe; write: one clock later
  wire logic ds_nxt = in_bus_nxt && (!write_nxt || (cnt_nxt >= 8'h01));
  wire logic oe_nxt = in_bus_nxt && write_nxt; // see RL24 RL8
  wire logic irq_nxt = irq_req && !halt_s && (state_r != ST_HOLD); // see RL9

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      left_r <= 3'h0;
      write_r <= 1'b0;
      fast_r <= 1'b0;
      iack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      left_r <= left_nxt;
      write_r <= write_nxt;
      fast_r <= fast_nxt;
      iack_r <= iack_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= 24'h000000;
      space_r <= 3'h0;
      op_r <= 32'h00000000;
      rd_r <= 32'h00000000;
    end else begin
      addr_r <= addr_nxt;
      space_r <= space_nxt;
      op_r <= op_nxt;
      rd_r <= rd_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_r <= 1'b0;
      fault_r <= 1'b0;
      auto_vector_in_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      fault_r <= fault_nxt;
      auto_vector_in_r <= auto_vector_in_nxt;
      irq_r <= irq_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      as_n_r <= 1'b1;
      ds_n_r <= 1'b1;
      oe_r <= 1'b0;
      wd_r <= 16'h0000;
    end else begin
      as_n_r <= !as_nxt;
      ds_n_r <= !ds_nxt;
      oe_r <= oe_nxt;
      wd_r <= mux_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign done = done_r;
  assign rdata = rd_r;
  assign fault = fault_r;
  assign autovec = auto_vector_in_r;
  assign irq_take = irq_r;
  assign addr_out = addr_r;
  assign space_code = space_r;
  assign remaining_size = left_r[1:0]; // see RL23
  assign read_not_write = !write_r;
  assign addr_strobe_n = as_n_r;
  assign data_strobe_n = ds_n_r;
  // a foreign master owns the pins; held values come back when it leaves
  assign bus_drive_en = !ext_master; // see RL8
  assign data_out = wd_r;
  assign data_oe = oe_r;

endmodule

// ---- logic/sync_two_flop.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // first stage feeds only the second stage
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ---- sim/bus_responder_model.sv ----
// behavioural memory responder on the external bus
`timescale 1ns/1ps
module bus_responder_model
  import ebi_pkg::*;
(
  // bus pins
  input wire logic clk,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_not_write,
  input wire logic [23:0] addr_out,
  input wire logic [15:0] data_out,
  output logic [1:0] size_ack_pair,
  output logic [15:0] data_in,
  // behaviour controls
  input wire logic port8,
  input wire logic slow,
  input wire logic silent,
  output logic [15:0] wr_data
);
  logic [3:0] cnt_r = 4'h0;
  logic [7:0] pat_r = 8'h00;
  logic [15:0] rd16;
  function automatic logic [7:0] mb(input logic [23:0] a);
    return a[7:0] ^ 8'ha5;
  endfunction
  // an 8-bit port sits on the upper lines only; free lines carry a moving pattern
  assign rd16 = port8 ? {mb(addr_out), pat_r} : {mb({addr_out[23:1], 1'b0}), mb({addr_out[23:1], 1'b1})};
  assign data_in = (!data_strobe_n && read_not_write) ? rd16 : {~pat_r, pat_r};
  initial size_ack_pair = ACK_WAIT;
  always @(posedge clk) begin
    pat_r <= pat_r + 8'h01;
    if (addr_strobe_n) begin
      cnt_r <= 4'h0;
      size_ack_pair <= ACK_WAIT;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      // own port width always; a write is stored on the same clock edge the ack goes out
      // a write is stored, and acked, only once the data strobe marks the bus valid
      if (!silent && size_ack_pair == ACK_WAIT && cnt_r >= (slow ? 4'h6 : 4'h0)
          && (read_not_write || !data_strobe_n)) begin
        size_ack_pair <= port8 ? ACK_PORT8 : ACK_PORT16;
        if (!read_not_write) wr_data <= data_out;
      end
    end
  end
endmodule

// ---- sim/ebu_props.sv ----
// concurrent checks on the external bus unit pins
`timescale 1ns/1ps
module ebu_props
  import ebi_pkg::*;
#(
  parameter logic [7:0] MON_CYC = MON_CYC_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // core side
  input wire logic req_ready,
  input wire logic req_internal,
  input wire logic req_fast,
  input wire logic ext_master,
  input wire logic done,
  input wire logic autovec,
  input wire logic irq_take,
  // bus pins
  input wire logic halt_in_n,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_not_write,
  input wire logic data_oe,
  input wire logic [2:0] space_code,
  input wire logic [23:0] addr_out,
  input wire logic [1:0] remaining_size
);
  // strobe low time, so a dead responder cannot hang the bus unseen
  logic [7:0] low_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) low_r <= 8'h00;
    else low_r <= addr_strobe_n ? 8'h00 : low_r + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_start;
    $fell(addr_strobe_n);
  endsequence
  sequence s_halted;
    !halt_in_n [*6];
  endsequence
  a_refuse_ext: assert property (ext_master && !req_internal |-> !req_ready)
    else $error("request taken while an outside master owns the bus");
  a_write_drive: assert property (!addr_strobe_n && !read_not_write |-> data_oe)
    else $error("write cycle without data drive");
  a_min_cycle: assert property (s_start ##0 !req_fast |-> !addr_strobe_n [*3])
    else $error("handshaked cycle shorter than three clocks");
  a_read_strobes: assert property (s_start ##0 read_not_write |-> !data_strobe_n)
    else $error("read data strobe not with address strobe");
  a_write_strobes: assert property (s_start ##0 !read_not_write |-> data_strobe_n ##1 !data_strobe_n)
    else $error("write data strobe not one clock late");
  a_halt_irq: assert property (!halt_in_n [*4] |-> !irq_take)
    else $error("interrupt taken while halted");
  a_halt_hold: assert property (s_halted ##0 addr_strobe_n |=> $stable(addr_out) && $stable(remaining_size) && !data_oe)
    else $error("bus pins moved while halted");
  a_auto_vector_in_cpu: assert property (done && autovec |-> space_code == SPACE_CPU)
    else $error("autovector end outside cpu space");
  a_monitor_bound: assert property (!addr_strobe_n |-> low_r <= MON_CYC + 8'h04)
    else $error("bus monitor did not end the cycle");
endmodule

bind external_bus_unit ebu_props #(.MON_CYC(MON_CYC)) ebu_props_inst (
  .clk(clk), .reset_n(reset_n), .req_ready(req_ready), .req_internal(req_internal), .req_fast(req_fast),
  .ext_master(ext_master), .done(done), .autovec(autovec), .irq_take(irq_take), .halt_in_n(halt_in_n),
  .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n), .read_not_write(read_not_write),
  .data_oe(data_oe), .space_code(space_code), .addr_out(addr_out), .remaining_size(remaining_size)
);

// ---- sim/test_external_bus_unit.sv ----
// self-checking bench for the external bus unit
`timescale 1ns/1ps
module test_external_bus_unit
  import ebi_pkg::*;
;
  logic clk = 0, reset_n = 0, req_valid = 0, req_write = 0, req_internal = 0, req_iack = 0, irq_req = 0;
  logic ext_master = 0, halt_in_n = 1, bus_fault_in_n = 1, auto_vector_in_n = 1, port8 = 0, slow = 0, silent = 0;
  logic [2:0] req_size = 3'h1, req_space = 3'h1, space_code;
  logic [23:0] req_addr = 24'h000000, addr_out;
  logic [31:0] req_wdata = 32'h0, int_rdata = 32'h0, rdata;
  logic req_ready, done, fault, autovec, irq_take, read_not_write, addr_strobe_n, data_strobe_n, bus_drive_en, data_oe;
  logic as_d = 1;
  logic [1:0] remaining_size, size_ack_pair;
  logic [15:0] data_out, data_in, wr_data;
  int error_cnt = 0, n_tests = 0;
  logic [1:0] sz_q[$];
  logic [23:0] ad_q[$];
  always #2.5 clk = ~clk;
  // monitor kept short so the fault case does not dominate run time, yet longer than the slow responder
  external_bus_unit #(.MON_CYC(8'h10)) external_bus_unit_inst (
    .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_size(req_size), .req_addr(req_addr), .req_space(req_space), .req_wdata(req_wdata),
    .req_internal(req_internal), .req_fast(1'b0), .req_iack(req_iack), .int_rdata(int_rdata),
    .cs_ack_pair(2'h3), .done(done), .rdata(rdata), .fault(fault), .autovec(autovec), .irq_req(irq_req),
    .irq_take(irq_take), .ext_master(ext_master), .addr_out(addr_out), .space_code(space_code),
    .remaining_size(remaining_size), .read_not_write(read_not_write), .addr_strobe_n(addr_strobe_n),
    .data_strobe_n(data_strobe_n), .bus_drive_en(bus_drive_en), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .size_ack_pair(size_ack_pair), .bus_fault_in_n(bus_fault_in_n),
    .halt_in_n(halt_in_n), .auto_vector_in_n(auto_vector_in_n));
  bus_responder_model bus_responder_model_inst (
    .clk(clk), .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n), .read_not_write(read_not_write),
    .addr_out(addr_out), .data_out(data_out), .size_ack_pair(size_ack_pair), .data_in(data_in),
    .port8(port8), .slow(slow), .silent(silent), .wr_data(wr_data));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    as_d <= addr_strobe_n;
    if (as_d === 1'b1 && addr_strobe_n === 1'b0) begin
      sz_q.push_back(remaining_size);
      ad_q.push_back(addr_out);
    end
  end
  function automatic logic [7:0] mb(input logic [23:0] a);
    return a[7:0] ^ 8'ha5;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic op(input logic wr, input logic [2:0] sz, input logic [23:0] a, input logic [31:0] wd,
                    input logic [2:0] sp, input logic ia, input logic intl);
    int n;
    @(negedge clk);
    sz_q.delete();
    ad_q.delete();
    {req_write, req_size, req_addr, req_wdata} = {wr, sz, a, wd};
    {req_space, req_iack, req_internal} = {sp, ia, intl};
    req_valid = 1;
    n = 0;
    #1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      #1;
      n++;
    end
    @(negedge clk);
    req_valid = 0;
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) chk(32'h0, 32'h1, "operation hung");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_word_write();
    slow = 1;
    op(1, OPSZ_WORD, 24'h000100, 32'h0000beef, 3'h1, 0, 0);
    slow = 0;
    chk({16'h0, wr_data}, 32'h0000beef, "word write data");
    chk({31'h0, fault}, 32'h0, "word write fault");
    chk(32'(sz_q.size()), 32'h1, "word write cycles");
    chk({30'h0, sz_q[0]}, {30'h0, RSZ_WORD}, "word size code");
  endtask
  task automatic t_long_reads();
    logic [1:0] c8 [4] = '{RSZ_LONG, RSZ_THREE, RSZ_WORD, RSZ_BYTE};
    for (int p = 0; p < 2; p++) begin
      port8 = p[0];
      op(0, OPSZ_LONG, 24'h000200, 32'h0, 3'h5, 0, 0);
      chk(rdata, {mb(24'h200), mb(24'h201), mb(24'h202), mb(24'h203)}, "long read data");
      chk(32'(sz_q.size()), p ? 32'h4 : 32'h2, "long read cycles");
      for (int i = 0; i < sz_q.size(); i++) begin
        chk({30'h0, sz_q[i]}, {30'h0, p ? c8[i] : (i == 0 ? RSZ_LONG : RSZ_WORD)}, "size code");
        chk({8'h0, ad_q[i]}, 32'h200 + 32'(p ? i : 2 * i), "cycle address");
      end
    end
    port8 = 0;
  endtask
  task automatic t_odd_bytes();
    op(0, OPSZ_BYTE, 24'h000301, 32'h0, 3'h1, 0, 0);
    chk({24'h0, rdata[7:0]}, {24'h0, mb(24'h301)}, "odd byte read");
    chk({30'h0, sz_q[0]}, {30'h0, RSZ_BYTE}, "byte size code");
    op(1, OPSZ_BYTE, 24'h000301, 32'h0000003c, 3'h1, 0, 0);
    chk({16'h0, wr_data}, 32'h00003c3c, "odd byte write lanes");
  endtask
  task automatic t_autovector();
    silent = 1;
    auto_vector_in_n = 0;
    op(0, OPSZ_BYTE, 24'h000003, 32'h0, SPACE_CPU, 1, 0);
    chk({30'h0, autovec, fault}, 32'h2, "autovector end");
    silent = 0;
    op(0, OPSZ_BYTE, 24'h000300, 32'h0, 3'h1, 0, 0);
    chk({31'h0, autovec}, 32'h0, "autovector ignored");
    auto_vector_in_n = 1;
  endtask
  task automatic t_faults();
    silent = 1;
    bus_fault_in_n = 0;
    op(0, OPSZ_WORD, 24'h000400, 32'h0, 3'h1, 0, 0);
    chk({31'h0, fault}, 32'h1, "pin fault");
    bus_fault_in_n = 1;
    op(0, OPSZ_WORD, 24'h000400, 32'h0, 3'h1, 0, 0);
    chk({31'h0, fault}, 32'h1, "monitor fault");
    silent = 0;
    op(0, OPSZ_WORD, 24'h000400, 32'h0, 3'h1, 0, 0);
    chk({31'h0, fault}, 32'h0, "fault cleared");
  endtask
  task automatic t_halt();
    halt_in_n = 0;
    irq_req = 1;
    repeat (4) @(negedge clk);
    req_valid = 1;
    #1;
    chk({31'h0, req_ready}, 32'h0, "halt refuses bus");
    req_valid = 0;
    chk({31'h0, irq_take}, 32'h0, "no interrupt halted");
    int_rdata = 32'h13572468;
    op(0, OPSZ_LONG, 24'h000010, 32'h0, 3'h5, 0, 1);
    chk(rdata, 32'h13572468, "internal under halt");
    halt_in_n = 1;
    repeat (4) @(negedge clk);
    chk({31'h0, irq_take}, 32'h1, "interrupt resumes");
    irq_req = 0;
    req_internal = 0;
    ext_master = 1;
    req_valid = 1;
    #1;
    chk({30'h0, req_ready, bus_drive_en}, 32'h0, "outside master");
    req_valid = 0;
    ext_master = 0;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1;
    t_word_write();
    t_long_reads();
    t_odd_bytes();
    t_autovector();
    t_faults();
    t_halt();
    conclude();
  end
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
endmodule
